// file: sarseq_pkg.sv
// Shared constants and types of the SAR conversion sequencer.
// Assumes one 100 MHz clock and a synchronous active-low reset.
package sarseq_pkg;
    // ************************************************************
    // Code layout
    // ************************************************************
    localparam int          CODE_W       = 16;
    localparam int          MSB_POS      = 15;
    localparam logic [15:0] TOP_CODE     = 16'hffff;
    localparam logic [15:0] BOTTOM_CODE  = 16'h0000;
    localparam logic [15:0] MSB_FLIP     = 16'h8000;
    localparam logic [15:0] FIRST_TRIAL  = 16'h8000;
    localparam logic [15:0] RESULT_RST   = 16'h0000;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          ACQ_TIME_NS   = 500;
    localparam int          ACQ_CYCLES    = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]  ACQ_LOAD      = 8'(ACQ_CYCLES - 1);
    localparam int          FIFO_DEPTH    = 16;
    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {ST_ACQ, ST_TRIAL, ST_FORM} sarseq_state_t;
    typedef struct packed {
        logic        over_range;
        logic        under_range;
        logic [15:0] code;
    } sarseq_result_t;
endpackage

// file: sarseq_fifo.sv
// Result FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module sarseq_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire              push = in_valid_i && in_ready_o;
    wire              pop  = out_valid_o && out_ready_i;

    assign in_ready_o  = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // sarseq_fifo

// file: sarseq_top.sv
// Sequencer of a 16-bit successive-approximation converter.
// Assumes the comparator and range detectors are synchronous to CLK_I.
// Functional notes
// - A falling edge on convert_start_n ends acquisition and starts a conversion.
// - At conversion start the sampling array and dummy are cut off the inputs and hold.
// - Sixteen bit decisions are made one per cycle, most significant bit first.
// - Each trial weight is half the previous, from half reference to one LSB.
// - After the last decision the code is formed, then busy goes low.
// - The code presented after busy falls belongs to the conversion just finished.
// - code_format_select picks straight binary or twos complement (MSB inverted).
// - Overrange saturates to FFFF straight binary or 7FFF twos complement.
// - Underrange saturates to 0000 straight binary or 8000 twos complement.
// - A running conversion ignores further start edges and power-down.
// - Start held low when busy is low re-triggers after self-timed acquisition.
`timescale 1ns/1ns
module sarseq_top (
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_B_I,
    // Host control
    input  wire logic        CONVERT_START_N_I,
    input  wire logic        CODE_FORMAT_SELECT_I,
    input  wire logic        POWER_DOWN_I,
    // Analog front end
    input  wire logic        COMPARATOR_I,
    input  wire logic        OVER_RANGE_I,
    input  wire logic        UNDER_RANGE_I,
    output logic             SAMPLE_HOLD_O,
    output logic [15:0]      DAC_SWITCH_O,
    // Status and result
    output logic             BUSY_O,
    output logic [15:0]      RESULT_O,
    // Result stream
    output logic             RES_VALID_O,
    input  wire logic        RES_READY_I,
    output logic [17:0]      RES_DATA_O
);
    // ************************************************************
    // State
    // ************************************************************
    sarseq_pkg::sarseq_state_t state;
    sarseq_pkg::sarseq_state_t next_state;
    logic [15:0]               trial_bit;
    logic [15:0]               sar;
    logic                      start_q;
    logic [7:0]                acq_cnt;
    logic                      over_q;
    logic                      under_q;
    logic                      fifo_ready;
    logic                      fifo_valid;
    logic [17:0]               fifo_data;
    logic                      push;
    sarseq_pkg::sarseq_result_t push_word;

    // ************************************************************
    // Decode
    // ************************************************************
    wire         start_fall  = start_q && !CONVERT_START_N_I;
    wire         start_low   = !CONVERT_START_N_I && acq_cnt == 8'h00;
    // Power-down only holds off new conversions; it never aborts one
    wire         may_start   = !POWER_DOWN_I && fifo_ready;
    wire         go          = (state == sarseq_pkg::ST_ACQ) && may_start
                               && (start_fall || start_low);
    wire         last_trial  = trial_bit[0];
    wire [15:0]  kept        = COMPARATOR_I ? (sar | trial_bit) : sar;
    wire [15:0]  straight    = over_q  ? sarseq_pkg::TOP_CODE
                             : under_q ? sarseq_pkg::BOTTOM_CODE : sar;
    wire [15:0]  formatted   = CODE_FORMAT_SELECT_I ? straight
                             : (straight ^ sarseq_pkg::MSB_FLIP);

    always_comb begin
        next_state = state;
        case (state)
            sarseq_pkg::ST_ACQ: begin
                if (go) begin
                    next_state = sarseq_pkg::ST_TRIAL;
                end
            end
            sarseq_pkg::ST_TRIAL: begin
                if (last_trial) begin
                    next_state = sarseq_pkg::ST_FORM;
                end
            end
            default: begin
                next_state = sarseq_pkg::ST_ACQ;
            end
        endcase
    end

    assign push      = (state == sarseq_pkg::ST_FORM);
    assign push_word = '{over_range: over_q, under_range: under_q, code: formatted};

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            state   <= sarseq_pkg::ST_ACQ;
            start_q <= 1'b1;
        end else begin
            state   <= next_state;
            start_q <= CONVERT_START_N_I;
        end
    end

    // Self-timed acquisition reloads whenever a conversion ends
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            acq_cnt <= 8'h00;
        end else if (push) begin
            acq_cnt <= sarseq_pkg::ACQ_LOAD;
        end else if (acq_cnt != 8'h00) begin
            acq_cnt <= acq_cnt - 8'h01;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            trial_bit <= 16'h0000;
            sar       <= 16'h0000;
            over_q    <= 1'b0;
            under_q   <= 1'b0;
        end else if (go) begin
            trial_bit <= sarseq_pkg::FIRST_TRIAL;
            sar       <= 16'h0000;
            over_q    <= OVER_RANGE_I;
            under_q   <= UNDER_RANGE_I;
        end else if (state == sarseq_pkg::ST_TRIAL) begin
            sar       <= kept;
            trial_bit <= trial_bit >> 1;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            SAMPLE_HOLD_O <= 1'b0;
            DAC_SWITCH_O  <= 16'h0000;
            BUSY_O        <= 1'b0;
            RESULT_O      <= sarseq_pkg::RESULT_RST;
        end else begin
            if (go) begin
                SAMPLE_HOLD_O <= 1'b1;
                BUSY_O        <= 1'b1;
                DAC_SWITCH_O  <= sarseq_pkg::FIRST_TRIAL;
            end else if (state == sarseq_pkg::ST_TRIAL && !last_trial) begin
                DAC_SWITCH_O  <= kept | (trial_bit >> 1);
            end else if (push) begin
                // Code lands in the same edge busy drops, so no stale read
                RESULT_O      <= formatted;
                BUSY_O        <= 1'b0;
                SAMPLE_HOLD_O <= 1'b0;
                DAC_SWITCH_O  <= 16'h0000;
            end
        end
    end

    // ************************************************************
    // Result stream
    // ************************************************************
    // The fifo pops exactly when the drain stage loads, so no word is repeated
    wire take = fifo_valid && (!RES_VALID_O || RES_READY_I);

    sarseq_fifo #(
        .WIDTH (18),
        .DEPTH (sarseq_pkg::FIFO_DEPTH)
    ) u_sarseq_fifo (
        .clk_i       (CLK_I),
        .rst_b_i     (RST_B_I),
        .in_valid_i  (push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (push_word),
        .out_valid_o (fifo_valid),
        .out_ready_i (take),
        .out_data_o  (fifo_data)
    );

    // Registered drain stage keeps stream outputs on flip-flops
    // Data loads only with a real word, so unwritten memory never shows
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            RES_VALID_O <= 1'b0;
            RES_DATA_O  <= 18'h00000;
        end else if (take) begin
            RES_VALID_O <= 1'b1;
            RES_DATA_O  <= fifo_data;
        end else if (RES_READY_I) begin
            RES_VALID_O <= 1'b0;
        end
    end
endmodule // sarseq_top

// file: sarseq_front_model.sv
// Front-end model: comparator against a sampled level, and a result reader.
// Assumes the bench sets the level before the conversion starts.
`timescale 1ns/1ns
module sarseq_front_model (
    // Clock and trial pattern
    input  wire logic        clk_i,
    input  wire logic [15:0] dac_i,
    input  wire logic [15:0] level_i,
    input  wire logic        stall_i,
    // Answers
    output logic             comp_o,
    output logic             ready_o = 1'b0
);
    logic [1:0] phase = 2'h0;
    // Keep the trial bit while the trial pattern on dac_i does not exceed the sample
    assign comp_o = (dac_i <= level_i);
    // Reader is slow every fourth cycle, so the stream sees back-pressure
    always_ff @(posedge clk_i) begin
        phase   <= phase + 2'h1;
        ready_o <= !stall_i && (phase != 2'h3);
    end
endmodule // sarseq_front_model

// file: sarseq_checker_props.sv
// Concurrent checks on the ports of the sequencer top.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module sarseq_checker (
    input wire logic        CLK_I, RST_B_I, CONVERT_START_N_I, CODE_FORMAT_SELECT_I,
    input wire logic        POWER_DOWN_I, COMPARATOR_I, OVER_RANGE_I, UNDER_RANGE_I,
    input wire logic        SAMPLE_HOLD_O, BUSY_O, RES_VALID_O, RES_READY_I,
    input wire logic [15:0] DAC_SWITCH_O, RESULT_O,
    input wire logic [17:0] RES_DATA_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    chk_start_pattern: assert property ($rose(BUSY_O) |->
        SAMPLE_HOLD_O && DAC_SWITCH_O == 16'h8000) else $error("start pattern wrong");
    chk_busy_hold: assert property (BUSY_O |-> SAMPLE_HOLD_O)
        else $error("array not held while busy");
    chk_msb_decide: assert property ($rose(BUSY_O) |=>
        DAC_SWITCH_O[15] == $past(COMPARATOR_I)) else $error("msb decision wrong");
    chk_second_step: assert property ($rose(BUSY_O) |=>
        DAC_SWITCH_O[14] && DAC_SWITCH_O[13:0] == 14'h0) else $error("second trial weight wrong");
    chk_last_trial: assert property ($rose(BUSY_O) |-> ##15 DAC_SWITCH_O[0])
        else $error("lsb trial missing");
    chk_busy_length: assert property ($rose(BUSY_O) |->
        BUSY_O[*8] ##1 BUSY_O[*8] ##1 BUSY_O ##1 !BUSY_O) else $error("busy length wrong");
    chk_over_code: assert property ($rose(BUSY_O) && $past(OVER_RANGE_I) |-> ##17
        RESULT_O == ($past(CODE_FORMAT_SELECT_I) ? 16'hffff : 16'h7fff))
        else $error("overrange code wrong");
    chk_under_code: assert property ($rose(BUSY_O) && $past(UNDER_RANGE_I) |-> ##17
        RESULT_O == ($past(CODE_FORMAT_SELECT_I) ? 16'h0000 : 16'h8000))
        else $error("underrange code wrong");
    chk_result_moment: assert property ($changed(RESULT_O) |-> $fell(BUSY_O))
        else $error("result changed off busy fall");
    chk_pd_block: assert property (POWER_DOWN_I && !BUSY_O |=> !BUSY_O)
        else $error("start taken in power down");
    chk_stream_hold: assert property (RES_VALID_O && !RES_READY_I |=>
        RES_VALID_O && $stable(RES_DATA_O)) else $error("stream result dropped");
endmodule // sarseq_checker
bind sarseq_top sarseq_checker u_sarseq_checker (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
    .CONVERT_START_N_I(CONVERT_START_N_I), .CODE_FORMAT_SELECT_I(CODE_FORMAT_SELECT_I),
    .POWER_DOWN_I(POWER_DOWN_I), .COMPARATOR_I(COMPARATOR_I), .OVER_RANGE_I(OVER_RANGE_I),
    .UNDER_RANGE_I(UNDER_RANGE_I), .SAMPLE_HOLD_O(SAMPLE_HOLD_O), .BUSY_O(BUSY_O),
    .RES_VALID_O(RES_VALID_O), .RES_READY_I(RES_READY_I), .DAC_SWITCH_O(DAC_SWITCH_O),
    .RESULT_O(RESULT_O), .RES_DATA_O(RES_DATA_O));

// file: sarseq_top_test.sv
// Self-checking bench of the sequencer top.
// Assumes the front-end model answers the comparator and reads results.
`timescale 1ns/1ns
module sarseq_top_test;
    logic        CLK_I = 0, RST_B_I = 0, CONVERT_START_N_I = 1, CODE_FORMAT_SELECT_I = 1;
    logic        POWER_DOWN_I = 0, OVER_RANGE_I = 0, UNDER_RANGE_I = 0, stall = 0;
    logic        COMPARATOR_I, SAMPLE_HOLD_O, BUSY_O, RES_VALID_O, RES_READY_I;
    logic [15:0] level = 16'h0, DAC_SWITCH_O, RESULT_O;
    logic [17:0] RES_DATA_O;
    logic [17:0] exp_q[$];
    int          n_fail = 0, n_compared = 0, n;
    sarseq_top u_sarseq_top (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
        .CONVERT_START_N_I(CONVERT_START_N_I), .CODE_FORMAT_SELECT_I(CODE_FORMAT_SELECT_I),
        .POWER_DOWN_I(POWER_DOWN_I), .COMPARATOR_I(COMPARATOR_I), .OVER_RANGE_I(OVER_RANGE_I),
        .UNDER_RANGE_I(UNDER_RANGE_I), .SAMPLE_HOLD_O(SAMPLE_HOLD_O), .DAC_SWITCH_O(DAC_SWITCH_O),
        .BUSY_O(BUSY_O), .RESULT_O(RESULT_O), .RES_VALID_O(RES_VALID_O),
        .RES_READY_I(RES_READY_I), .RES_DATA_O(RES_DATA_O));
    sarseq_front_model u_sarseq_front_model (.clk_i(CLK_I), .dac_i(DAC_SWITCH_O), .level_i(level),
        .stall_i(stall), .comp_o(COMPARATOR_I), .ready_o(RES_READY_I));
    initial forever #5 CLK_I = ~CLK_I;
    task automatic check(input string what, input logic [17:0] e, input logic [17:0] s);
        n_compared++;
        if (e !== s) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic complete_run;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Bounded wait for busy to reach a level; n holds the cycles spent
    task automatic wait_busy(input logic v, input int lim);
        n = 0;
        while (BUSY_O !== v && n < lim) begin
            @(posedge CLK_I);
            #1 n++;
        end
        check("busy level", 18'(v), 18'(BUSY_O));
        if (BUSY_O !== v) complete_run;
    endtask
    task automatic drain;
        n = 0;
        while (exp_q.size() > 0 && n < 400) begin
            @(posedge CLK_I);
            #1 n++;
        end
        check("pending results", 18'h0, 18'(exp_q.size()));
        if (exp_q.size() > 0) complete_run;
    endtask
    // One start pulse; go says whether the start must be taken
    task automatic conv(input logic [15:0] lvl, input logic fmt, ov, un, go, pd);
        logic [15:0] b;
        b = ov ? 16'hffff : (un ? 16'h0000 : lvl);
        b = fmt ? b : b ^ 16'h8000;
        @(posedge CLK_I);
        #1 {level, CODE_FORMAT_SELECT_I, OVER_RANGE_I, UNDER_RANGE_I} = {lvl, fmt, ov, un};
        CONVERT_START_N_I = 0;
        @(posedge CLK_I);
        #1 CONVERT_START_N_I = 1;
        if (!go) begin
            repeat (3) @(posedge CLK_I);
            #1 check("refused start", 18'h0, 18'(BUSY_O));
            return;
        end
        exp_q.push_back({ov, un, b});
        wait_busy(1, 3);
        if (pd) begin
            @(posedge CLK_I);
            #1 {CONVERT_START_N_I, POWER_DOWN_I} = 2'b01;
            @(posedge CLK_I);
            #1 CONVERT_START_N_I = 1;
        end
        wait_busy(0, 25);
        check("result", {2'b0, b}, {2'b0, RESULT_O});
        if (pd) POWER_DOWN_I = 0;
    endtask
    always @(posedge CLK_I) begin
        if (RST_B_I && RES_VALID_O === 1'b1 && RES_READY_I === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_fail++;
                $display("[ERR] result stream expected none seen %h", RES_DATA_O);
            end else
                check("result stream", exp_q.pop_front(), RES_DATA_O);
        end
    end
    initial begin
        n = $urandom(26180);
        repeat (3) @(posedge CLK_I);
        #1 RST_B_I = 1;
        for (int i = 0; i < 4; i++) conv(16'h1234, i[0], i[1], !i[1], 1, 0);
        conv(16'h8000, 0, 0, 0, 1, 0);
        repeat (12) conv(16'($urandom), 1'($urandom), 0, 0, 1, 0);
        conv(16'($urandom), 1, 0, 0, 1, 1);
        // Power-down is raised one cycle later, never in the step that lowered it
        @(posedge CLK_I);
        #1 POWER_DOWN_I = 1;
        conv(16'h0f0f, 1, 0, 0, 0, 0);
        POWER_DOWN_I = 0;
        // Held-low start: the second conversion must start itself
        @(posedge CLK_I);
        #1 {CONVERT_START_N_I, CODE_FORMAT_SELECT_I, level} = {2'b01, 16'h5a5a};
        exp_q.push_back({2'b0, 16'h5a5a});
        wait_busy(1, 3);
        wait_busy(0, 25);
        wait_busy(1, 100);
        check("auto gap", 18'h1,
              18'(n >= sarseq_pkg::ACQ_CYCLES && n <= sarseq_pkg::ACQ_CYCLES + 2));
        exp_q.push_back({2'b0, 16'h5a5a});
        CONVERT_START_N_I = 1;
        wait_busy(0, 25);
        drain();
        // Reader stalls until sixteen words plus the output stage fill up
        stall = 1;
        repeat (17) conv(16'($urandom), 1, 0, 0, 1, 0);
        conv(16'h0001, 1, 0, 0, 0, 0);
        stall = 0;
        drain();
        complete_run;
    end
endmodule // sarseq_top_test
